// ==== rtl/periodic_timer.sv ====
// Mode logic of the 10-bit periodic timer: compare, timer, PWM, single pulse, capture
// Notes on behaviour
// - Compare mode, clear_select 0: P match clears the counter.
// - clear_select 1: A match clears the counter; P flag never raised.
// - Compare mode: pin changes only on A flag or enable rise; P match leaves it alone.
// - Enable rising edge returns the pin to its initial level.
// - Mode 11 counts and flags like compare mode; pin not driven.
// - PWM: P match clears counter; P 0 gives 1024 counts, else P counts.
// - PWM: duty value at or above period gives 100% duty.
// - PWM: A and P matches each raise their own flag.
// - PWM: output_control sets active level, function forces, polarity inverts.
// - PWM: counting continues while the pin is forced.
// - PWM: clear_select ignored; period comparator always clears.
// - Single pulse: external clock pin rising edge sets the enable bit.
// - Single pulse: A match clears enable, ends pulse, raises A flag.
// - Single pulse: counter zeroed only by enable rising edge.
// - Mode 01 captures from a timer pin or external clock pin.
// - Capture: selected edge copies counter into compare A, raises A flag.
// - Capture: counter free-runs; P match zeroes it and raises P flag.
// - Capture: function 11 disables capture; counter keeps running.
// - Capture: clear_select, output_control, polarity ignored; no output.
// - Capture edge: 00 rising, 01 falling, 10 both.
// - Counter is 10 bits; A value zero overflows at 3FF, no A flag.
// - clear_select 0 with P value zero clears on overflow.
`timescale 1ns/1ps
`default_nettype none
module periodic_timer
    import periodic_timer_pkg::*;
#(
    parameter int W = CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Module clock tick
    input wire logic count_tick,
    // Control bits
    input wire logic mode_sel_hi,
    input wire logic mode_sel_lo,
    input wire logic out_func_hi,
    input wire logic out_func_lo,
    input wire logic output_control,
    input wire logic output_polarity,
    input wire logic capture_source_sel,
    input wire logic capture_pin_sel,
    input wire logic clear_select,
    // Enable bit write
    input wire logic enable_wr,
    input wire logic enable_wdata,
    // Compare values
    input wire logic compare_a_wr,
    input wire logic [W-1:0] compare_a_wdata,
    input wire logic [W-1:0] compare_p_value,
    // Flag clears
    input wire logic cmp_a_flag_clr,
    input wire logic cmp_p_flag_clr,
    // External pins
    input wire logic timer_pin_0,
    input wire logic timer_pin_1,
    input wire logic ext_clock_pin,
    // Status
    output logic module_enable,
    output logic [W-1:0] counter_value,
    output logic [W-1:0] compare_a_value,
    output logic cmp_a_flag,
    output logic cmp_p_flag,
    // Waveform pin
    output logic timer_out,
    output logic timer_out_en
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (W != CNT_W) begin : g_bad_width
        $error("periodic_timer: counter width must be 10");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta, rst_n;
    // Async assert, sync release through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Decodes and edges
    // ------------------------------------------------------------
    logic [1:0] mode, func;
    logic enable_prev, ena_rise, pin_prev, ext_prev, cap_src, cap_edge, ext_rise;
    logic [W-1:0] cnt_inc;
    logic pulse_mode, run, a_hit, p_hit, clr_on_a, wave_active;
    assign mode = {mode_sel_hi, mode_sel_lo};
    assign func = {out_func_hi, out_func_lo};
    assign pulse_mode = (mode == MODE_PWM) && (func == FUNC_PULSE);
    assign ena_rise = module_enable && !enable_prev;
    // Pins are taken as synchronous; one flop gives the previous level
    assign cap_src = capture_source_sel ? ext_clock_pin
                   : (capture_pin_sel ? timer_pin_1 : timer_pin_0);
    assign ext_rise = ext_clock_pin && !ext_prev;
    // Edge type from the output function bits
    always_comb begin
        case (func)
            FUNC_RISE: cap_edge = cap_src && !pin_prev;
            FUNC_FALL: cap_edge = !cap_src && pin_prev;
            FUNC_BOTH: cap_edge = cap_src != pin_prev;
            default: cap_edge = 1'b0;
        endcase
    end
    // Previous levels of enable and pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_prev <= 1'b0;
            pin_prev <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            enable_prev <= module_enable;
            pin_prev <= cap_src;
            ext_prev <= ext_clock_pin;
        end
    end

    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------
    // Matching on count+1 makes a zero value fall on the wrap at 3FF
    assign run = module_enable && !ena_rise && count_tick;
    assign cnt_inc = counter_value + W'(1);
    assign clr_on_a = clear_select && (mode == MODE_COMPARE || mode == MODE_TIMER);
    assign a_hit = run && (cnt_inc == compare_a_value) && (compare_a_value != '0);
    assign p_hit = run && (cnt_inc == compare_p_value);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Enable rise zeroes; otherwise count, clearing on the chosen match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value <= CNT_RESET;
        end else if (ena_rise) begin
            counter_value <= CNT_RESET;
        end else if (run) begin
            if (pulse_mode) begin
                counter_value <= cnt_inc;
            end else if (clr_on_a) begin
                counter_value <= a_hit ? CNT_RESET : cnt_inc;
            end else begin
                counter_value <= p_hit ? CNT_RESET : cnt_inc;
            end
        end
    end

    // ------------------------------------------------------------
    // Enable bit
    // ------------------------------------------------------------
    // Software write, pin start and A-match stop in pulse mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            module_enable <= 1'b0;
        end else if (enable_wr) begin
            module_enable <= enable_wdata;
        end else if (pulse_mode && a_hit) begin
            module_enable <= 1'b0;
        end else if (pulse_mode && ext_rise) begin
            module_enable <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Compare A register
    // ------------------------------------------------------------
    // Capture overrides a software write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_a_value <= CMP_A_RESET;
        end else if (mode == MODE_CAPTURE && module_enable && cap_edge) begin
            compare_a_value <= counter_value;
        end else if (compare_a_wr) begin
            compare_a_value <= compare_a_wdata;
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    logic set_a, set_p;
    assign set_a = (mode == MODE_CAPTURE) ? (module_enable && cap_edge) : a_hit;
    assign set_p = p_hit && !clr_on_a && !pulse_mode;
    // Sticky flags; a set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_a_flag <= 1'b0;
            cmp_p_flag <= 1'b0;
        end else begin
            cmp_a_flag <= set_a || (cmp_a_flag && !cmp_a_flag_clr);
            cmp_p_flag <= set_p || (cmp_p_flag && !cmp_p_flag_clr);
        end
    end

    // ------------------------------------------------------------
    // Output pin
    // ------------------------------------------------------------
    logic cmp_level, next_out, next_out_en;
    // Compare-mode level: initial on enable rise, action on A flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_level <= 1'b0;
        end else if (ena_rise) begin
            cmp_level <= output_control;
        end else if (a_hit) begin
            case (func)
                FUNC_LOW: cmp_level <= 1'b0;
                FUNC_HIGH: cmp_level <= 1'b1;
                FUNC_TOGGLE: cmp_level <= !cmp_level;
                default: cmp_level <= cmp_level;
            endcase
        end
    end
    // Duty at or above a nonzero period holds the wave active
    assign wave_active = ((compare_a_value >= compare_p_value) && (compare_p_value != '0))
                       || (counter_value < compare_a_value);
    // Pin level per mode; the pulse ends at the pin one cycle after enable drops
    always_comb begin
        next_out = 1'b0;
        next_out_en = 1'b0;
        case (mode)
            MODE_COMPARE: begin
                next_out = cmp_level ^ output_polarity;
                next_out_en = 1'b1;
            end
            MODE_PWM: begin
                next_out_en = 1'b1;
                case (func)
                    FUNC_INACTIVE: next_out = !output_control;
                    FUNC_ACTIVE: next_out = output_control;
                    FUNC_PWM: next_out = wave_active ? output_control : !output_control;
                    default: next_out = module_enable ? output_control : !output_control;
                endcase
                next_out = next_out ^ output_polarity;
            end
            default: next_out_en = 1'b0;
        endcase
    end
    // Registered pin drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_out <= 1'b0;
            timer_out_en <= 1'b0;
        end else begin
            timer_out <= next_out;
            timer_out_en <= next_out_en;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_tick_match_p;
        run && !pulse_mode && !clr_on_a && (cnt_inc == compare_p_value);
    endsequence
    sequence s_zero_next;
        counter_value == '0;
    endsequence
    property p_clear_on_p;
        @(posedge clk) disable iff (!rst_n) s_tick_match_p |=> s_zero_next;
    endproperty
    a_clear_on_p: assert property (p_clear_on_p)
        else $error("counter not cleared on P match");
    property p_no_p_flag_sel_a;
        @(posedge clk) disable iff (!rst_n)
            (clear_select && mode == MODE_COMPARE && !cmp_p_flag) ##1
            (clear_select && mode == MODE_COMPARE) |-> !cmp_p_flag;
    endproperty
    a_no_p_flag_sel_a: assert property (p_no_p_flag_sel_a)
        else $error("P flag raised with clear on A");
    property p_pin_hold_no_a;
        @(posedge clk) disable iff (!rst_n)
            (mode == MODE_COMPARE && !a_hit && !ena_rise) ##1 (mode == MODE_COMPARE)
            |-> $stable(cmp_level);
    endproperty
    a_pin_hold_no_a: assert property (p_pin_hold_no_a)
        else $error("compare level moved without A match");
    property p_init_on_rise;
        @(posedge clk) disable iff (!rst_n) ena_rise |=> cmp_level == $past(output_control);
    endproperty
    a_init_on_rise: assert property (p_init_on_rise)
        else $error("pin not returned to initial level");
    property p_timer_no_drive;
        @(posedge clk) disable iff (!rst_n)
            (mode == MODE_TIMER || mode == MODE_CAPTURE) |=> !timer_out_en;
    endproperty
    a_timer_no_drive: assert property (p_timer_no_drive)
        else $error("pin driven in timer or capture mode");
    property p_full_duty;
        @(posedge clk) disable iff (!rst_n)
            (mode == MODE_PWM && func == FUNC_PWM && compare_p_value != '0 &&
             compare_a_value >= compare_p_value && !output_polarity)
            |=> timer_out == $past(output_control);
    endproperty
    a_full_duty: assert property (p_full_duty)
        else $error("duty not held at 100 percent");
    property p_pulse_stop;
        @(posedge clk) disable iff (!rst_n)
            (pulse_mode && a_hit && !enable_wr) |=> !module_enable && cmp_a_flag;
    endproperty
    a_pulse_stop: assert property (p_pulse_stop)
        else $error("pulse not ended by A match");
    property p_pin_start;
        @(posedge clk) disable iff (!rst_n)
            (pulse_mode && ext_rise && !module_enable && !enable_wr) |=> module_enable ##1 counter_value == '0;
    endproperty
    a_pin_start: assert property (p_pin_start)
        else $error("pin edge did not start pulse");
    property p_capture;
        @(posedge clk) disable iff (!rst_n)
            (mode == MODE_CAPTURE && module_enable && cap_edge)
            |=> compare_a_value == $past(counter_value) && cmp_a_flag;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not copy counter");
    property p_hold_disabled;
        @(posedge clk) disable iff (!rst_n)
            (!module_enable && !enable_prev) |=> $stable(counter_value);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled)
        else $error("counter moved while disabled");
endmodule : periodic_timer
`default_nettype wire

// ==== pkg/periodic_timer_pkg.sv ====
// Constants shared by the periodic timer mode logic
package periodic_timer_pkg;
    // ------------------------------------------------------------
    // Counter geometry
    // ------------------------------------------------------------
    localparam int CNT_W = 10;
    localparam logic [9:0] CNT_RESET = 10'h000;
    localparam logic [9:0] CMP_A_RESET = 10'h000;
    // ------------------------------------------------------------
    // Mode select encodings {mode_sel_hi, mode_sel_lo}
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    // ------------------------------------------------------------
    // Output function encodings {out_func_hi, out_func_lo}
    // ------------------------------------------------------------
    localparam logic [1:0] FUNC_NONE = 2'h0;
    localparam logic [1:0] FUNC_LOW = 2'h1;
    localparam logic [1:0] FUNC_HIGH = 2'h2;
    localparam logic [1:0] FUNC_TOGGLE = 2'h3;
    localparam logic [1:0] FUNC_INACTIVE = 2'h0;
    localparam logic [1:0] FUNC_ACTIVE = 2'h1;
    localparam logic [1:0] FUNC_PWM = 2'h2;
    localparam logic [1:0] FUNC_PULSE = 2'h3;
    localparam logic [1:0] FUNC_RISE = 2'h0;
    localparam logic [1:0] FUNC_FALL = 2'h1;
    localparam logic [1:0] FUNC_BOTH = 2'h2;
    localparam logic [1:0] FUNC_NOCAP = 2'h3;
endpackage : periodic_timer_pkg

// ==== dv/timer_pin_model.sv ====
// Model of the external capture and trigger pins around the timer
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
    // Clock
    input wire logic clk,
    // Pins driven toward the timer
    output logic timer_pin_0,
    output logic timer_pin_1,
    output logic ext_clock_pin,
    // Waveform pin seen from outside
    input wire logic timer_out,
    input wire logic timer_out_en
);
    // Pins idle low
    initial begin
        timer_pin_0 = 1'b0;
        timer_pin_1 = 1'b0;
        ext_clock_pin = 1'b0;
    end

    // Move one pin just after an edge; held long enough for the edge detector
    task automatic drive_pin(input logic [1:0] which, input logic lvl);
        @(posedge clk);
        case (which)
            2'd0: timer_pin_0 <= lvl;
            2'd1: timer_pin_1 <= lvl;
            default: ext_clock_pin <= lvl;
        endcase
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : drive_pin
endmodule : timer_pin_model
`default_nettype wire

// ==== dv/periodic_timer_modes_test.sv ====
// Self-checking bench for the periodic timer mode logic
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_modes_test;
    import periodic_timer_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic tick = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [1:0] func = 2'h0;
    logic oc = 1'b0;
    logic pol = 1'b0;
    logic csrc = 1'b0;
    logic clr_sel = 1'b0;
    logic psel = 1'b0;
    logic en_wr = 1'b0;
    logic en_d = 1'b0;
    logic a_wr = 1'b0;
    logic [9:0] a_d = 10'h000;
    logic [9:0] p_val = 10'h000;
    logic f_clr = 1'b0;
    wire logic p0, p1, ck, ena, a_flag, p_flag, t_out, t_en;
    wire logic [9:0] cnt;
    wire logic [9:0] a_val;
    int error_cnt = 0;
    int compares = 0;
    int cmax;
    int hi_cnt;
    logic [9:0] held;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    periodic_timer dut (
        .clk(clk), .reset_n(reset_n), .count_tick(tick),
        .mode_sel_hi(mode[1]), .mode_sel_lo(mode[0]),
        .out_func_hi(func[1]), .out_func_lo(func[0]),
        .output_control(oc), .output_polarity(pol), .capture_source_sel(csrc),
        .capture_pin_sel(psel), .clear_select(clr_sel),
        .enable_wr(en_wr), .enable_wdata(en_d), .compare_a_wr(a_wr),
        .compare_a_wdata(a_d), .compare_p_value(p_val),
        .cmp_a_flag_clr(f_clr), .cmp_p_flag_clr(f_clr),
        .timer_pin_0(p0), .timer_pin_1(p1), .ext_clock_pin(ck),
        .module_enable(ena), .counter_value(cnt), .compare_a_value(a_val),
        .cmp_a_flag(a_flag), .cmp_p_flag(p_flag),
        .timer_out(t_out), .timer_out_en(t_en)
    );

    timer_pin_model pins (
        .clk(clk), .timer_pin_0(p0), .timer_pin_1(p1), .ext_clock_pin(ck),
        .timer_out(t_out), .timer_out_en(t_en)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // Ends on a falling edge so results of the last rising edge have landed
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic set_en(input logic v);
        @(posedge clk);
        en_wr <= 1'b1;
        en_d <= v;
        @(posedge clk);
        en_wr <= 1'b0;
        cyc(4);
    endtask : set_en

    task automatic wr_a(input logic [9:0] v);
        @(posedge clk);
        a_wr <= 1'b1;
        a_d <= v;
        @(posedge clk);
        a_wr <= 1'b0;
        cyc(2);
    endtask : wr_a

    task automatic clr_flags();
        @(posedge clk);
        f_clr <= 1'b1;
        @(posedge clk);
        f_clr <= 1'b0;
        cyc(2);
    endtask : clr_flags

    // Timer stopped while mode bits change, as software must do
    task automatic setup(input logic [1:0] m, input logic [1:0] f, input logic o,
                         input logic cs, input logic [9:0] p, input logic [9:0] a,
                         input logic en);
        set_en(1'b0);
        @(posedge clk);
        mode <= m;
        func <= f;
        oc <= o;
        pol <= 1'b0;
        clr_sel <= cs;
        p_val <= p;
        tick <= 1'b1;
        wr_a(a);
        clr_flags();
        if (en) begin
            set_en(1'b1);
        end
    endtask : setup

    // Largest count and cycles with the pin high over a window
    task automatic run(input int n);
        cmax = 0;
        hi_cnt = 0;
        repeat (n) begin
            @(negedge clk);
            if (cnt > cmax) cmax = cnt;
            if (t_out === 1'b1) hi_cnt++;
        end
    endtask : run

    // Bounded wait on the enable bit
    task automatic wait_en(input logic v);
        int i;
        for (i = 0; i < 60; i++) begin
            @(negedge clk);
            if (ena === v) return;
        end
        error_cnt++;
        $display("ERROR module_enable expected %0b seen %0b", v, ena);
        finish_test();
    endtask : wait_en

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic compare_mode();
        setup(MODE_COMPARE, FUNC_HIGH, 1'b0, 1'b0, 10'h003, 10'h002, 1'b1);
        run(40);
        check("cmax", 11'(cmax), 11'd2);
        check("p_flag", 11'(p_flag), 11'd1);
        check("t_out", 11'(t_out), 11'd1);
        check("t_en", 11'(t_en), 11'd1);
        set_en(1'b0);
        held = cnt;
        run(8);
        check("cnt hold", 11'(cnt), 11'(held));
        @(posedge clk);
        tick <= 1'b0;
        set_en(1'b1);
        check("t_out init", 11'(t_out), 11'd0);
        check("cnt zero", 11'(cnt), 11'd0);
        setup(MODE_COMPARE, FUNC_HIGH, 1'b0, 1'b0, 10'h003, 10'h000, 1'b1);
        run(40);
        check("a_flag", 11'(a_flag), 11'd0);
        check("t_out", 11'(t_out), 11'd0);
    endtask : compare_mode

    task automatic clear_on_a();
        setup(MODE_COMPARE, FUNC_TOGGLE, 1'b0, 1'b1, 10'h002, 10'h005, 1'b1);
        run(40);
        check("cmax", 11'(cmax), 11'd4);
        check("p_flag", 11'(p_flag), 11'd0);
        check("hi_cnt", 11'(hi_cnt), 11'd20);
    endtask : clear_on_a

    task automatic timer_mode();
        setup(MODE_TIMER, FUNC_TOGGLE, 1'b1, 1'b0, 10'h003, 10'h002, 1'b1);
        run(40);
        check("cmax", 11'(cmax), 11'd2);
        check("a_flag", 11'(a_flag), 11'd1);
        check("p_flag", 11'(p_flag), 11'd1);
        check("t_en", 11'(t_en), 11'd0);
    endtask : timer_mode

    task automatic pwm_mode();
        setup(MODE_PWM, FUNC_PWM, 1'b1, 1'b1, 10'h004, 10'h001, 1'b1);
        run(40);
        check("cmax", 11'(cmax), 11'd3);
        check("hi_cnt", 11'(hi_cnt), 11'd10);
        check("a_flag", 11'(a_flag), 11'd1);
        check("p_flag", 11'(p_flag), 11'd1);
        wr_a(10'h004);
        cyc(8);
        run(40);
        check("hi_cnt", 11'(hi_cnt), 11'd40);
        @(posedge clk);
        pol <= 1'b1;
        cyc(4);
        run(40);
        check("hi_cnt", 11'(hi_cnt), 11'd0);
        setup(MODE_PWM, FUNC_INACTIVE, 1'b1, 1'b0, 10'h004, 10'h001, 1'b1);
        run(40);
        check("hi_cnt", 11'(hi_cnt), 11'd0);
        check("cmax", 11'(cmax), 11'd3);
        setup(MODE_PWM, FUNC_ACTIVE, 1'b1, 1'b0, 10'h004, 10'h001, 1'b1);
        run(40);
        check("hi_cnt", 11'(hi_cnt), 11'd40);
        setup(MODE_PWM, FUNC_PWM, 1'b1, 1'b0, 10'h000, 10'h200, 1'b1);
        run(1024);
        check("cmax", 11'(cmax), 11'h3FF);
        check("hi_cnt", 11'(hi_cnt), 11'd512);
    endtask : pwm_mode

    task automatic single_pulse();
        setup(MODE_PWM, FUNC_PULSE, 1'b1, 1'b0, 10'h002, 10'h006, 1'b0);
        pins.drive_pin(2'd2, 1'b1);
        wait_en(1'b1);
        cyc(1);
        check("t_out", 11'(t_out), 11'd1);
        wait_en(1'b0);
        cyc(2);
        check("t_out", 11'(t_out), 11'd0);
        check("a_flag", 11'(a_flag), 11'd1);
        check("p_flag", 11'(p_flag), 11'd0);
        check("cnt", 11'(cnt), 11'd6);
        @(posedge clk);
        tick <= 1'b0;
        set_en(1'b1);
        check("cnt", 11'(cnt), 11'd0);
    endtask : single_pulse

    task automatic capture_mode();
        setup(MODE_CAPTURE, FUNC_RISE, 1'b1, 1'b1, 10'h005, 10'h000, 1'b1);
        run(20);
        check("cmax", 11'(cmax), 11'd4);
        check("p_flag", 11'(p_flag), 11'd1);
        check("t_en", 11'(t_en), 11'd0);
        @(posedge clk);
        tick <= 1'b0;
        clr_flags();
        held = cnt;
        pins.drive_pin(2'd0, 1'b1);
        check("a_val", 11'(a_val), 11'(held));
        check("a_flag", 11'(a_flag), 11'd1);
        @(posedge clk);
        func <= FUNC_FALL;
        clr_flags();
        pins.drive_pin(2'd0, 1'b0);
        check("a_flag", 11'(a_flag), 11'd1);
        @(posedge clk);
        func <= FUNC_NOCAP;
        tick <= 1'b1;
        clr_flags();
        pins.drive_pin(2'd0, 1'b1);
        check("a_flag", 11'(a_flag), 11'd0);
        check("p_flag", 11'(p_flag), 11'd1);
        @(posedge clk);
        func <= FUNC_BOTH;
        csrc <= 1'b1;
        clr_flags();
        pins.drive_pin(2'd2, 1'b0);
        check("a_flag", 11'(a_flag), 11'd1);
        @(posedge clk);
        func <= FUNC_RISE;
        csrc <= 1'b0;
        psel <= 1'b1;
        clr_flags();
        pins.drive_pin(2'd1, 1'b1);
        check("a_flag pin1", 11'(a_flag), 11'd1);
    endtask : capture_mode

    // Reset held three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        compare_mode();
        clear_on_a();
        timer_mode();
        pwm_mode();
        single_pulse();
        capture_mode();
        finish_test();
    end
endmodule : periodic_timer_modes_test
`default_nettype wire
